// ### src/sdap_top.sv
`timescale 1ns/1ns
`include "sdap_consts.svh"
module sdap_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic bit_clock,
  input wire logic frame_sync,
  output logic serial_data
);
  import sdap_pkg::*;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] word_bits(input sdap_len_t len);
    case (len)
      SDAP_LEN8: word_bits = 6'h08;
      SDAP_LEN16: word_bits = 6'h10;
      SDAP_LEN20: word_bits = 6'h14;
      default: word_bits = 6'h18;
    endcase
  endfunction

  // samples sit in the low bits; move the first bit up to bit 23
  function automatic logic [23:0] align(
    input logic [23:0] v,
    input sdap_len_t len
  );
    case (len)
      SDAP_LEN8: align = {v[7:0], 16'h0000};
      SDAP_LEN16: align = {v[15:0], 8'h00};
      SDAP_LEN20: align = {v[19:0], 4'h0};
      default: align = v;
    endcase
  endfunction

  // ---------------- register side, aclk ----------------
  logic awready_q, wready_q, bvalid_q;
  logic [1:0] bresp_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic arready_q, rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  sdap_ctrl_t ctrl_q, ctrl_d;
  logic [23:0] left_q, left_d, right_q, right_d;
  logic pending_q, pending_d, req_q;
  logic underrun_q, underrun_d;
  logic ack_s1_q, ack_s2_q;
  logic urun_s1_q, urun_s2_q, urun_s3_q;
  logic ack_q, urun_tgl_q;

  wire aw_hs = awvalid & awready_q;
  wire w_hs = wvalid & wready_q;
  wire ar_hs = arvalid & arready_q;
  wire do_write = ~awready_q & ~wready_q & ~bvalid_q;

  wire sel_ctrl = awaddr_q == `SDAP_OFF_CTRL;
  wire sel_left = awaddr_q == `SDAP_OFF_LEFT;
  wire sel_right = awaddr_q == `SDAP_OFF_RIGHT;
  wire sel_stat = awaddr_q == `SDAP_OFF_STAT;
  // sample registers are frozen while a pair waits for the link
  wire smp_ok = ~pending_q;
  wire wr_ok = sel_ctrl | sel_stat | ((sel_left | sel_right) & smp_ok);

  wire [31:0] ctrl_wr = merge({25'h0, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] left_wr = merge({8'h00, left_q}, wdata_q, wstrb_q);
  wire [31:0] right_wr = merge({8'h00, right_q}, wdata_q, wstrb_q);

  wire commit_w = do_write & sel_right & smp_ok;
  wire ack_seen = pending_q & (ack_s2_q == req_q);
  wire urun_ev = urun_s2_q ^ urun_s3_q;
  wire urun_clr = do_write & sel_stat & wstrb_q[0] & wdata_q[`SDAP_STAT_URUN];

  assign ctrl_d = (do_write & sel_ctrl) ? sdap_ctrl_t'(ctrl_wr[6:0]) : ctrl_q;
  assign left_d = (do_write & sel_left & smp_ok) ? left_wr[23:0] : left_q;
  assign right_d = commit_w ? right_wr[23:0] : right_q;
  assign pending_d = commit_w ? 1'b1 : (ack_seen ? 1'b0 : pending_q);
  // a new underrun beats a clear in the same cycle
  assign underrun_d = urun_ev | (underrun_q & ~urun_clr);

  wire [7:0] ra = araddr[7:0];
  wire [31:0] stat_w = {30'h0, underrun_q, pending_q};
  wire rd_hit = (ra == `SDAP_OFF_CTRL) | (ra == `SDAP_OFF_LEFT) |
                (ra == `SDAP_OFF_RIGHT) | (ra == `SDAP_OFF_STAT);
  wire [31:0] rd_w = (ra == `SDAP_OFF_CTRL) ? {25'h0, ctrl_q} :
                     (ra == `SDAP_OFF_LEFT) ? {8'h00, left_q} :
                     (ra == `SDAP_OFF_RIGHT) ? {8'h00, right_q} :
                     (ra == `SDAP_OFF_STAT) ? stat_w : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `SDAP_RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        awaddr_q <= awaddr[7:0];
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `SDAP_RESP_OKAY : `SDAP_RESP_SLVERR;
      end
      if (bvalid_q & bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `SDAP_RESP_OKAY;
      rdata_q <= 32'h00000000;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_w;
      rresp_q <= rd_hit ? `SDAP_RESP_OKAY : `SDAP_RESP_SLVERR;
    end else if (rvalid_q & rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sdap_ctrl_t'(`SDAP_CTRL_RST);
      left_q <= `SDAP_SAMPLE_RST;
      right_q <= `SDAP_SAMPLE_RST;
      pending_q <= 1'b0;
      req_q <= 1'b0;
      underrun_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      urun_s1_q <= 1'b0;
      urun_s2_q <= 1'b0;
      urun_s3_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      left_q <= left_d;
      right_q <= right_d;
      pending_q <= pending_d;
      req_q <= req_q ^ commit_w;
      underrun_q <= underrun_d;
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
      urun_s1_q <= urun_tgl_q;
      urun_s2_q <= urun_s1_q;
      urun_s3_q <= urun_s2_q;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  a_resp_after_both: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bvalid_q) |-> $past(~awready_q & ~wready_q))
    else $error("write answered before address and data");
  a_ready_return: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q & bready) |=> (awready_q & wready_q & ~bvalid_q))
    else $error("write channels not reopened");
  a_read_single: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> (rvalid_q & ~arready_q))
    else $error("read not answered next cycle");
  a_pair_held: assert property (@(posedge aclk) disable iff (!aresetn)
    (pending_q & ~ack_seen) |=> (pending_q & $stable(left_q) & $stable(right_q)))
    else $error("queued pair changed before link took it");

  // ---------------- link side ----------------
  // output flop moves on the edge opposite the capture edge
  // cap_fall must only change while the port is disabled
  wire drive_clk = ctrl_q.cap_fall ? bit_clock : ~bit_clock;

  logic lrst_s1_q, lrst_s2_q;
  sdap_ctrl_t lcfg_s1_q, lcfg_q;
  logic req_s1_q, req_s2_q, fs_q;
  sdap_lstate_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [47:0] sh_q, sh_d;
  logic [23:0] hold_l_q, hold_r_q;
  logic out_q, out_d;

  // frame_sync belongs to the bit_clock domain; its edges start words (in DSP only its rising edge) and, outside DSP, its level picks the channel
  wire fs_edge = frame_sync ^ fs_q;
  wire fs_rise = frame_sync & ~fs_q;
  wire is_dsp = lcfg_q.fmt == SDAP_FMT_DSP;
  wire is_lj = lcfg_q.fmt == SDAP_FMT_LJ;
  wire start_w = lcfg_q.enable & (is_dsp ? fs_rise : fs_edge);
  wire left_w = is_dsp | (is_lj ? frame_sync : ~frame_sync);
  wire late_w = is_dsp ? lcfg_q.dsp_second : ~is_lj;
  wire take_w = start_w & left_w & (req_s2_q != ack_q);

  wire [23:0] src_l = take_w ? left_q : hold_l_q;
  wire [23:0] src_r = take_w ? right_q : hold_r_q;
  wire [23:0] al_l = align(src_l, lcfg_q.len);
  wire [23:0] al_r = align(src_r, lcfg_q.len);
  wire [5:0] nbits = word_bits(lcfg_q.len);
  wire [5:0] total = is_dsp ? {nbits[4:0], 1'b0} : nbits;
  // right word packed straight behind the left one
  wire [47:0] dsp_word = {al_l, 24'h000000} | ({al_r, 24'h000000} >> nbits);
  wire [47:0] load_w = is_dsp ? dsp_word : {(left_w ? al_l : al_r), 24'h000000};
  wire [47:0] sh_next = {sh_q[46:0], 1'b0};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = 1'b0;
    if (!lcfg_q.enable) begin
      st_d = SDAP_IDLE;
    end else if (start_w) begin
      cnt_d = total - 6'h01;
      if (late_w) begin
        st_d = SDAP_LEAD;
        sh_d = load_w;
      end else begin
        st_d = SDAP_SHIFT;
        out_d = load_w[47];
        sh_d = {load_w[46:0], 1'b0};
      end
    end else begin
      case (st_q)
        SDAP_LEAD: begin
          st_d = SDAP_SHIFT;
          out_d = sh_q[47];
          sh_d = sh_next;
        end
        SDAP_SHIFT: begin
          if (cnt_q == 6'h00) begin
            st_d = SDAP_TAIL;
          end else begin
            out_d = sh_q[47];
            sh_d = sh_next;
            cnt_d = cnt_q - 6'h01;
          end
        end
        SDAP_TAIL: st_d = SDAP_TAIL;
        SDAP_IDLE: st_d = SDAP_IDLE;
        default: st_d = SDAP_IDLE;
      endcase
    end
  end

  // link reset only takes hold while bit_clock runs
  always_ff @(posedge drive_clk) begin
    lrst_s1_q <= aresetn;
    lrst_s2_q <= lrst_s1_q;
  end

  always_ff @(posedge drive_clk) begin
    if (!lrst_s2_q) begin
      lcfg_s1_q <= sdap_ctrl_t'(`SDAP_CTRL_RST);
      lcfg_q <= sdap_ctrl_t'(`SDAP_CTRL_RST);
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q <= 1'b0;
      urun_tgl_q <= 1'b0;
      fs_q <= 1'b0;
      st_q <= SDAP_IDLE;
      cnt_q <= 6'h00;
      sh_q <= 48'h000000000000;
      hold_l_q <= `SDAP_SAMPLE_RST;
      hold_r_q <= `SDAP_SAMPLE_RST;
      out_q <= 1'b0;
    end else begin
      lcfg_s1_q <= ctrl_q;
      lcfg_q <= lcfg_s1_q;
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      fs_q <= frame_sync;
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      if (take_w) begin
        ack_q <= req_s2_q;
        hold_l_q <= left_q;
        hold_r_q <= right_q;
      end
      // no fresh pair at a frame start: the old one is resent
      if (start_w & left_w & ~take_w) begin
        urun_tgl_q <= ~urun_tgl_q;
      end
    end
  end

  assign serial_data = out_q;

  a_late_lead: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (start_w & late_w) |=> (st_q == SDAP_LEAD && !out_q) ##1
      (st_q == SDAP_SHIFT && out_q == $past(sh_q[47])))
    else $error("delayed first bit slot wrong");
  a_early_msb: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (start_w & ~late_w) |=> (st_q == SDAP_SHIFT && out_q == $past(load_w[47])))
    else $error("first bit not on first edge");
  a_dsp_select: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (start_w & is_dsp) |=> ((st_q == SDAP_LEAD) == $past(lcfg_q.dsp_second)))
    else $error("dsp first bit option ignored");
  a_msb_order: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (st_q == SDAP_SHIFT && cnt_q != 6'h00 && !start_w && lcfg_q.enable) |=>
      (out_q == $past(sh_q[47]) && cnt_q == $past(cnt_q) - 6'h01))
    else $error("bit order broken");
  a_word_count: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (start_w & ~late_w) |=> (cnt_q == $past(total) - 6'h01))
    else $error("bits per frame wrong");
  a_tail_low: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (st_q == SDAP_SHIFT && cnt_q == 6'h00 && !start_w && lcfg_q.enable) |=>
      (st_q == SDAP_TAIL && !out_q) [*2])
    else $error("spare cycles not low");
  a_i2s_channel: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (start_w && lcfg_q.fmt == SDAP_FMT_I2S && !frame_sync) |=>
      (sh_q == $past(load_w) && $past(left_w)))
    else $error("i2s left word not on low frame_sync");
  a_lj_channel: assert property (@(posedge drive_clk) disable iff (!lrst_s2_q)
    (start_w && is_lj) |=> (out_q == $past(frame_sync ? al_l[23] : al_r[23])))
    else $error("left-justified channel order wrong");

endmodule

// ### include/sdap_consts.svh
`ifndef SDAP_CONSTS_SVH
`define SDAP_CONSTS_SVH

// register byte offsets, low address byte only
`define SDAP_OFF_CTRL 8'h00
`define SDAP_OFF_LEFT 8'h04
`define SDAP_OFF_RIGHT 8'h08
`define SDAP_OFF_STAT 8'h0C

// control word: {cap_fall, dsp_second, len[1:0], fmt[1:0], enable}
`define SDAP_CTRL_W 7
`define SDAP_CTRL_RST 7'h08

`define SDAP_SAMPLE_W 24
`define SDAP_SAMPLE_RST 24'h000000

// status bits
`define SDAP_STAT_PEND 0
`define SDAP_STAT_URUN 1

`define SDAP_RESP_OKAY 2'h0
`define SDAP_RESP_SLVERR 2'h2

`endif

// ### include/sdap_pkg.sv
package sdap_pkg;

  typedef enum logic [1:0] {
    SDAP_FMT_I2S = 2'h0,
    SDAP_FMT_LJ = 2'h1,
    SDAP_FMT_DSP = 2'h2,
    SDAP_FMT_RSVD = 2'h3
  } sdap_fmt_t;

  typedef enum logic [1:0] {
    SDAP_LEN8 = 2'h0,
    SDAP_LEN16 = 2'h1,
    SDAP_LEN20 = 2'h2,
    SDAP_LEN24 = 2'h3
  } sdap_len_t;

  typedef struct packed {
    logic cap_fall;
    logic dsp_second;
    sdap_len_t len;
    sdap_fmt_t fmt;
    logic enable;
  } sdap_ctrl_t;

  // gray order along idle, lead, shift, tail
  typedef enum logic [1:0] {
    SDAP_IDLE = 2'b00,
    SDAP_LEAD = 2'b01,
    SDAP_SHIFT = 2'b11,
    SDAP_TAIL = 2'b10
  } sdap_lstate_t;

endpackage

// ### sim/sdap_master.sv
`timescale 1ns/1ns
// audio clock master: makes bit_clock and frame_sync, captures serial_data per slot (per two-slot frame in DSP)
module sdap_master #(
  parameter int SLOT = 32
) (
  input wire logic cap_fall,
  input wire logic dsp,
  input wire logic serial_data,
  output logic bit_clock,
  output logic frame_sync,
  output logic [63:0] unit_q,
  output logic unit_fs,
  output int n_unit
);
  logic [63:0] sh;
  int cnt;

  // bit clock runs free: the port needs it even in reset; phase unrelated to aclk
  initial begin
    bit_clock = 1'b0;
    #7;
    forever #32 bit_clock = ~bit_clock;
  end

  // frame_sync moves only on capture edges so it is steady at the drive edges;
  // a level slot hands over only its own bits, the slot before is masked off
  initial begin
    frame_sync = 1'b0;
    sh = 64'h0;
    cnt = 0;
    n_unit = 0;
    unit_fs = 1'b0;
    unit_q = 64'h0;
    forever begin
      @(bit_clock);
      if (bit_clock ^ cap_fall) begin
        sh = {sh[62:0], serial_data};
        cnt = cnt + 1;
        if (dsp) begin
          if (cnt >= 2 * SLOT) begin
            unit_q = sh;
            n_unit++;
            cnt = 0;
            frame_sync = 1'b1;
          end else begin
            frame_sync = 1'b0;
          end
        end else if (cnt >= SLOT) begin
          unit_q = sh & ((64'h1 << SLOT) - 64'h1);
          unit_fs = frame_sync;
          n_unit++;
          cnt = 0;
          frame_sync = ~frame_sync;
        end
      end
    end
  end
endmodule

// ### sim/tb_slave_digital_audio_serial_port.sv
`timescale 1ns/1ns
`include "sdap_consts.svh"
module tb_slave_digital_audio_serial_port;
  import sdap_pkg::*;
  localparam int SLOT = 32;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, bit_clock, frame_sync, serial_data;
  logic m_fall, m_dsp, unit_fs;
  logic [31:0] awaddr, wdata, araddr, rdata, seed, rd;
  logic [2:0] awprot, arprot;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [63:0] unit_q;
  logic [6:0] cfg [7] = '{7'h08, 7'h5A, 7'h04, 7'h74, 7'h06, 7'h02, 7'h58};
  int n_unit, n_fail, n_tests;

  sdap_top u_sdap_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_data(serial_data));

  sdap_master #(.SLOT(SLOT)) u_sdap_master (.cap_fall(m_fall), .dsp(m_dsp),
    .serial_data(serial_data), .bit_clock(bit_clock), .frame_sync(frame_sync),
    .unit_q(unit_q), .unit_fs(unit_fs), .n_unit(n_unit));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [63:0] exp_unit(input sdap_ctrl_t c, input logic [23:0] l,
    input logic [23:0] r, input logic left);
    int n;
    logic [63:0] m;
    n = (c.len == SDAP_LEN8) ? 8 : (c.len == SDAP_LEN16) ? 16 : (c.len == SDAP_LEN20) ? 20 : 24;
    m = (64'h1 << n) - 64'h1;
    if (c.fmt == SDAP_FMT_DSP)
      return (((64'(l) & m) << n) | (64'(r) & m)) << (2 * SLOT - 2 * n - c.dsp_second);
    return ((left ? 64'(l) : 64'(r)) & m) << (SLOT - n - (c.fmt != SDAP_FMT_LJ));
  endfunction

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (k == 64) begin
      n_fail++;
      close_out;
    end
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (k == 64) begin
      n_fail++;
      close_out;
    end
    @(posedge aclk);
  endtask

  task automatic next_unit(output logic [63:0] u, output logic f);
    int k, n0;
    n0 = n_unit;
    for (k = 0; k < 3000 && n_unit == n0; k++) @(posedge aclk);
    if (k == 3000) begin
      n_fail++;
      close_out;
    end
    u = unit_q;
    f = unit_fs;
  endtask

  initial begin
    int i, k;
    sdap_ctrl_t c;
    logic [63:0] u;
    logic f;
    logic [23:0] l, r;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, m_fall, m_dsp} = 7'h00;
    awaddr = 32'h0;
    araddr = 32'h0;
    wdata = 32'h0;
    awprot = 3'h0;
    arprot = 3'h0;
    wstrb = 4'hF;
    seed = 32'h9979B271;
    n_fail = 0;
    n_tests = 0;
    // longer than six cycles: the link reset needs a few bit_clock edges
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(`SDAP_OFF_CTRL, rd, rs);
    chk("ctrl_reset", rd, 32'h08);
    rd_reg(8'h10, rd, rs);
    chk("unmapped_rresp", {rs, rd}, {`SDAP_RESP_SLVERR, 32'h0});
    wr_reg(8'h14, 32'h1, rs);
    chk("unmapped_bresp", rs, `SDAP_RESP_SLVERR);
    for (i = 0; i < 7; i++) begin
      c = sdap_ctrl_t'(cfg[i]);
      seed = lfsr(seed);
      l = seed[23:0];
      seed = lfsr(seed);
      r = seed[23:0];
      wr_reg(`SDAP_OFF_CTRL, {25'h0, c}, rs);
      m_fall <= c.cap_fall;
      m_dsp <= (c.fmt == SDAP_FMT_DSP);
      wr_reg(`SDAP_OFF_LEFT, {8'h0, l}, rs);
      wr_reg(`SDAP_OFF_RIGHT, {8'h0, r}, rs);
      chk("pair_bresp", rs, `SDAP_RESP_OKAY);
      // pair stays queued while disabled, so a second write must be refused
      wr_reg(`SDAP_OFF_LEFT, {8'h0, ~l}, rs);
      chk("busy_bresp", rs, `SDAP_RESP_SLVERR);
      rd_reg(`SDAP_OFF_LEFT, rd, rs);
      chk("left_held", rd, {8'h0, l});
      c.enable = 1'b1;
      wr_reg(`SDAP_OFF_CTRL, {25'h0, c}, rs);
      for (k = 0; k < 500; k++) begin
        rd_reg(`SDAP_OFF_STAT, rd, rs);
        if (rd[`SDAP_STAT_PEND] === 1'b0) break;
      end
      chk("pending", rd[`SDAP_STAT_PEND], 1'b0);
      if (c.fmt == SDAP_FMT_DSP) begin
        next_unit(u, f);
        chk("dsp_frame", u, exp_unit(c, l, r, 1'b0));
      end else begin
        for (k = 0; k < 3; k++) begin
          next_unit(u, f);
          if (f === (c.fmt == SDAP_FMT_LJ)) break;
        end
        chk("left_word", u, exp_unit(c, l, r, 1'b1));
        next_unit(u, f);
        chk("right_word", u, exp_unit(c, l, r, 1'b0));
      end
      c.enable = 1'b0;
      wr_reg(`SDAP_OFF_CTRL, {25'h0, c}, rs);
      $display("test %0d done", i);
    end
    // each run meets a left start with no fresh pair before it is disabled
    repeat (20) @(posedge aclk);
    rd_reg(`SDAP_OFF_STAT, rd, rs);
    chk("underrun_set", rd, 32'h1 << `SDAP_STAT_URUN);
    wr_reg(`SDAP_OFF_STAT, 32'h1 << `SDAP_STAT_URUN, rs);
    rd_reg(`SDAP_OFF_STAT, rd, rs);
    chk("underrun_clr", rd, 32'h0);
    $display("test status done");
    close_out;
  end
endmodule
